//--- pkg/parallel_io_map.svh
// Purpose: offsets, response codes and reset values for the shared parallel io port
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: pins are 16 per port
//
// Function
// - per pin, two muxes pick peripheral or port for output data and enable
// - port output data never loops back into a sharing peripheral's input
// - actively driving peripheral disables port driver; pin stays readable
// - enabled but idle peripheral lets the port drive the pin
// - direction bit one means input, zero means output
// - any reset returns every direction bit to input
// - latch register reads stored latch and writes update it
// - pin register reads pin levels; writing it updates the latch
// - unimplemented bits read zero in latch, direction and pin value
// - pin shared only with input-only function acts as dedicated port pin
// - open-drain bit set drives only low; cleared gives push-pull
// - cleared analog select bit makes pin analog; analog pins reset analog
// - with two converters, cleared bit in either makes pin analog
// - analog pins read zero in the pin-value register
// - digital input pins are not routed to the converter
`ifndef PARALLEL_IO_MAP_SVH
`define PARALLEL_IO_MAP_SVH

`define PRT_OFF_DIRECTION      12'h000
`define PRT_OFF_PIN_VALUE      12'h004
`define PRT_OFF_OUTPUT_LATCH   12'h008
`define PRT_OFF_OPEN_DRAIN     12'h00C
`define PRT_OFF_ANALOG_CFG1    12'h010
`define PRT_OFF_ANALOG_CFG2    12'h014
`define PRT_RST_DIRECTION      16'hFFFF
`define PRT_RST_ZERO           16'h0000
`define PRT_RESP_OKAY          2'h0
`define PRT_RESP_SLVERR        2'h2

`endif

//--- pkg/parallel_io_pkg.sv
// Purpose: types for the shared parallel io port
// Assumes: 16-bit port
// Notes: none
package parallel_io_pkg;
   typedef struct packed {
      logic [15:0] enabled;   // peripheral enabled on pin
      logic [15:0] active;    // peripheral actively driving
      logic [15:0] data;      // peripheral output data
      logic [15:0] oe;        // peripheral output enable
   } periph_drive_t;

   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
   } pin_drive_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } wr_state_t;
endpackage

//--- rtl/shared_parallel_io_port.sv
// Purpose: shared parallel io port with AXI4-Lite registers
// Assumes: aclk 100 MHz, synchronous active-low reset
// Notes: one write and one read in flight at a time
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "parallel_io_map.svh"

module shared_parallel_io_port #(
   parameter logic [15:0] IMPL_MASK   = 16'hFFFF,  // bits present on this variant
   parameter logic [15:0] ANALOG_MASK = 16'h00FF,  // bits with an analog function
   parameter logic [15:0] INONLY_MASK = 16'h0000   // bits shared only with input-only use
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [11:0]                   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [11:0]                   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire parallel_io_pkg::periph_drive_t periph,
   output logic [15:0]                        periph_in,
   output logic [15:0]                        analog_connect,
   input  wire logic [15:0]                   pin_in,
   output logic [15:0]                        pin_out,
   output logic [15:0]                        pin_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0]                 direction_reg;
   logic [15:0]                 output_latch_reg;
   logic [15:0]                 open_drain_ctl_reg;
   logic [15:0]                 analog_cfg_low_reg;   // first converter
   logic [15:0]                 analog_cfg_high_reg;  // second converter
   logic [15:0]                 pin_meta;
   logic [15:0]                 pin_sync;
   parallel_io_pkg::wr_state_t  wr_state;
   logic                        aw_held;
   logic                        w_held;
   logic [11:0]                 aw_addr;
   logic [31:0]                 w_data;
   logic [3:0]                  w_strb;

   ////////////////////////////////////////////////////////////////////////////
   // pin path
   wire logic [15:0] analog_pin  = ANALOG_MASK & ~(analog_cfg_low_reg & analog_cfg_high_reg);
   wire logic [15:0] shared_pin  = ~INONLY_MASK;
   wire logic [15:0] periph_own  = periph.enabled & periph.active & shared_pin;
   wire logic [15:0] port_oe     = ~direction_reg & IMPL_MASK;
   wire logic [15:0] port_drive_en = port_oe & ~(open_drain_ctl_reg & output_latch_reg);
   wire logic [15:0] port_data   = output_latch_reg & ~open_drain_ctl_reg;
   wire logic [15:0] pin_value   = pin_sync & ~analog_pin & IMPL_MASK;

   // output data and enable muxes; port driver off while peripheral owns pin
   assign pin_out        = (periph_own & periph.data) | (~periph_own & port_data);
   assign pin_oe         = (periph_own & periph.oe) | (~periph_own & port_drive_en);
   // peripheral sees the pad level only, never the latch; masked when port drives
   assign periph_in      = pin_sync & ~(port_drive_en & ~periph_own);
   assign analog_connect = analog_pin;

   // first flop read only by the second
   always_ff @(posedge aclk) begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi write
   wire logic        aw_take   = s_axi_awvalid & s_axi_awready;
   wire logic        w_take    = s_axi_wvalid & s_axi_wready;
   wire logic        have_aw   = aw_held | aw_take;
   wire logic        have_w    = w_held | w_take;
   wire logic [11:0] wr_addr   = aw_held ? aw_addr : s_axi_awaddr;
   wire logic [31:0] wr_data   = w_held ? w_data : s_axi_wdata;
   wire logic [3:0]  wr_strb   = w_held ? w_strb : s_axi_wstrb;
   wire logic        wr_fire   = (wr_state == parallel_io_pkg::WR_IDLE) & have_aw & have_w;
   wire logic [15:0] strb_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire logic [15:0] wr_val    = wr_data[15:0];
   wire logic        wr_dir    = wr_fire & (wr_addr == `PRT_OFF_DIRECTION);
   wire logic        wr_lat    = wr_fire & ((wr_addr == `PRT_OFF_OUTPUT_LATCH) |
                                            (wr_addr == `PRT_OFF_PIN_VALUE));
   wire logic        wr_odc    = wr_fire & (wr_addr == `PRT_OFF_OPEN_DRAIN);
   wire logic        wr_an1    = wr_fire & (wr_addr == `PRT_OFF_ANALOG_CFG1);
   wire logic        wr_an2    = wr_fire & (wr_addr == `PRT_OFF_ANALOG_CFG2);
   wire logic        wr_hit    = wr_dir | wr_lat | wr_odc | wr_an1 | wr_an2;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                         input logic [15:0] m);
      merge = (old & ~m) | (val & m & IMPL_MASK);
   endfunction

   assign s_axi_awready = (wr_state == parallel_io_pkg::WR_IDLE) & ~aw_held;
   assign s_axi_wready  = (wr_state == parallel_io_pkg::WR_IDLE) & ~w_held;
   assign s_axi_bvalid  = (wr_state == parallel_io_pkg::WR_RESP);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state    <= parallel_io_pkg::WR_IDLE;
         aw_held     <= 1'b0;
         w_held      <= 1'b0;
         aw_addr     <= 12'h000;
         w_data      <= 32'h00000000;
         w_strb      <= 4'h0;
         s_axi_bresp <= `PRT_RESP_OKAY;
      end else begin
         case (wr_state)
            parallel_io_pkg::WR_IDLE: begin
               if (wr_fire) begin
                  wr_state    <= parallel_io_pkg::WR_RESP;
                  aw_held     <= 1'b0;
                  w_held      <= 1'b0;
                  s_axi_bresp <= wr_hit ? `PRT_RESP_OKAY : `PRT_RESP_SLVERR;
               end else begin
                  if (aw_take) begin
                     aw_held <= 1'b1;
                     aw_addr <= s_axi_awaddr;
                  end
                  if (w_take) begin
                     w_held <= 1'b1;
                     w_data <= s_axi_wdata;
                     w_strb <= s_axi_wstrb;
                  end
               end
            end
            parallel_io_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= parallel_io_pkg::WR_IDLE;
               end
            end
            default: wr_state <= parallel_io_pkg::WR_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         direction_reg       <= `PRT_RST_DIRECTION;
         output_latch_reg    <= `PRT_RST_ZERO;
         open_drain_ctl_reg  <= `PRT_RST_ZERO;
         analog_cfg_low_reg  <= `PRT_RST_ZERO;
         analog_cfg_high_reg <= `PRT_RST_ZERO;
      end else begin
         if (wr_dir) direction_reg <= merge(direction_reg, wr_val, strb_mask) | ~IMPL_MASK;
         if (wr_lat) output_latch_reg <= merge(output_latch_reg, wr_val, strb_mask);
         if (wr_odc) open_drain_ctl_reg <= merge(open_drain_ctl_reg, wr_val, strb_mask);
         if (wr_an1) analog_cfg_low_reg <= merge(analog_cfg_low_reg, wr_val, strb_mask);
         if (wr_an2) analog_cfg_high_reg <= merge(analog_cfg_high_reg, wr_val, strb_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read; pin read two cycles after pin change through synchroniser
   wire logic [11:0] rd_addr = s_axi_araddr;
   wire logic        rd_hit  = (rd_addr == `PRT_OFF_DIRECTION) | (rd_addr == `PRT_OFF_PIN_VALUE) |
                               (rd_addr == `PRT_OFF_OUTPUT_LATCH) | (rd_addr == `PRT_OFF_OPEN_DRAIN) |
                               (rd_addr == `PRT_OFF_ANALOG_CFG1) | (rd_addr == `PRT_OFF_ANALOG_CFG2);
   logic [15:0] rd_word;
   always_comb begin
      case (rd_addr)
         `PRT_OFF_DIRECTION:    rd_word = direction_reg & IMPL_MASK;
         `PRT_OFF_PIN_VALUE:    rd_word = pin_value;
         `PRT_OFF_OUTPUT_LATCH: rd_word = output_latch_reg & IMPL_MASK;
         `PRT_OFF_OPEN_DRAIN:   rd_word = open_drain_ctl_reg;
         `PRT_OFF_ANALOG_CFG1:  rd_word = analog_cfg_low_reg;
         `PRT_OFF_ANALOG_CFG2:  rd_word = analog_cfg_high_reg;
         default:               rd_word = 16'h0000;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `PRT_RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {16'h0000, rd_word};
         s_axi_rresp  <= rd_hit ? `PRT_RESP_OKAY : `PRT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // shared_parallel_io_port

//--- verif/pio_pad_model.sv
// Purpose: pads and board on the far side of the port pins
// Assumes: every pad has a board pull-up; outside drivers never fight the port
// Notes: a released open-drain pad rises through the pull-up
`timescale 1ns/100ps
module pad_model (
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   input  wire logic [15:0] ext_level,
   input  wire logic [15:0] ext_oe,
   output logic      [15:0] pin_in
);
   // released pads go to the pull-up, never keep the last value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (~ext_oe | ext_level));
endmodule // pad_model

//--- verif/shared_parallel_io_port_properties.sv
// Purpose: port-level checks of the shared parallel io port
// Assumes: one clock, synchronous active-low reset
// Notes: register contents stay hidden here, so the bench judges them
`timescale 1ns/100ps
module shared_parallel_io_port_properties #(
   parameter logic [15:0] IMPL_MASK   = 16'hFFFF,
   parameter logic [15:0] INONLY_MASK = 16'h0000
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire parallel_io_pkg::periph_drive_t periph,
   input wire logic [15:0] periph_in,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe
);
   // input-only sharers never own a pin
   wire [15:0] own = periph.enabled & periph.active & ~INONLY_MASK;
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
   sequence unmapped_rd; rd_taken ##0 s_axi_araddr > 12'h014; endsequence
   a_owner_data: assert property ((pin_out & own) == (periph.data & own))
      else $error("owned pin not carrying peripheral data");
   a_owner_enable: assert property ((pin_oe & own) == (periph.oe & own))
      else $error("owned pin enable not from peripheral");
   a_no_loopback: assert property ((periph_in & pin_oe & ~own) == 16'h0000)
      else $error("port output seen by peripheral input");
   a_sync_two: assert property ($past(aresetn) && $past(aresetn, 2) |->
      (periph_in & IMPL_MASK) == ($past(pin_in, 2) & IMPL_MASK & ~(pin_oe & ~own)))
      else $error("peripheral input not two cycles behind pin");
   a_reset_inputs: assert property (disable iff (1'b0)
      !aresetn |=> (pin_oe & ~own) == 16'h0000) else $error("port drives pin after reset");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_unmapped: assert property (unmapped_rd |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 &&
      (s_axi_rdata[15:0] & ~IMPL_MASK) == 16'h0000) else $error("absent bits read nonzero");
endmodule // shared_parallel_io_port_properties
bind shared_parallel_io_port shared_parallel_io_port_properties #(.IMPL_MASK(IMPL_MASK),
   .INONLY_MASK(INONLY_MASK)) i_shared_parallel_io_port_properties (.*);

//--- verif/shared_parallel_io_port_test.sv
// Purpose: self-checking bench for the shared parallel io port
// Assumes: aclk 100 MHz, sync active-low reset held 6 cycles
// Notes: bit 15 absent and bit 2 input-only, to reach those paths
`timescale 1ns/100ps
module shared_parallel_io_port_test;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] periph_in, analog_connect, pin_in, pin_out, pin_oe;
   logic [15:0] ext_level, ext_oe, lvl;
   logic [33:0] expect_q[$];
   int          err_total, checks_done, i;
   parallel_io_pkg::periph_drive_t periph;
   shared_parallel_io_port #(.IMPL_MASK(16'h7FFF), .INONLY_MASK(16'h0004))
      i_shared_parallel_io_port (.*);
   pad_model i_pad_model (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   function automatic logic [15:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      checks_done++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one master for both directions; the extra edge keeps valids from being re-driven at once
   task automatic xfer(input bit wr, input logic [11:0] a, input logic [15:0] d,
                       input logic [33:0] want);
      bit done = 0;
      expect_q.push_back(want);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {16'h0000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid || s_axi_rvalid) begin
            {s_axi_bready, s_axi_rready} <= 2'b00;
            done = 1;
         end
      end
      if (!done) err_total++;
      if (!done) give_verdict();
      @(posedge aclk);
   endtask
   always @(posedge aclk)
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
         check(s_axi_bvalid ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp},
               expect_q.pop_front());
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_level, ext_oe} = '0;
      s_axi_wstrb = 4'hF;
      periph = '0;
      seed = 32'h4B70;
      err_total = 0;
      checks_done = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      xfer(0, 12'h000, 16'h0, {32'h0000_7FFF, 2'h0});
      check(pin_oe, 16'h0000);
      xfer(0, 12'h010, 16'h0, 34'h0);
      check(analog_connect, 16'h00FF);
      for (i = 0; i < 4; i++) begin
         lvl = xorshift();
         xfer(1, i[0] ? 12'h004 : 12'h008, lvl, 34'h0);
         xfer(0, 12'h008, 16'h0, {16'h0, lvl & 16'h7FFF, 2'h0});
      end
      xfer(1, 12'h000, 16'h00F0, 34'h0);
      xfer(1, 12'h008, 16'hA5A5, 34'h0);
      xfer(1, 12'h00C, 16'h000C, 34'h0);
      check({pin_oe, pin_out & pin_oe}, {16'h7F0B, 16'h2501});
      ext_oe <= 16'h80F0;
      ext_level <= xorshift();
      xfer(1, 12'h010, 16'hFFFF, 34'h0);
      xfer(1, 12'h014, 16'hFFDF, 34'h0);
      check(analog_connect, 16'h0020);
      lvl = 16'h2501 | (~16'h7F0B & (~ext_oe | ext_level));
      xfer(0, 12'h004, 16'h0, {16'h0, lvl & 16'h7FDF, 2'h0});
      periph <= '{enabled: 16'h0007, active: 16'h0005, data: 16'h0002, oe: 16'h0007};
      repeat (3) @(posedge aclk);
      check({pin_oe, pin_out & pin_oe}, {16'h7F0B, 16'h2500});
      check(periph_in & 16'h7F0A, 16'h0000);
      xfer(0, 12'h004, 16'h0, {16'h0, lvl & 16'h7FDE, 2'h0});
      xfer(1, 12'h020, 16'h1234, {32'h0, 2'h2});
      xfer(0, 12'h020, 16'h0, {32'h0, 2'h2});
      xfer(0, 12'h008, 16'h0, {32'h0000_25A5, 2'h0});
      give_verdict();
   end
endmodule // shared_parallel_io_port_test
